// ==== watch_timer_pkg.sv ====
// constants for the watchdog / power-down interlock block
package watch_timer_pkg;
   localparam int CNT_W = 16;
   // clock mode register bit positions
   localparam int MODE_TIMER_EN_BIT = 1;
   localparam int MODE_OSC_EN_BIT = 2;
   localparam logic [7:0] MODE_REG_RST = 8'h06;
   // synchroniser slots for the two pins
   localparam int SYNC_PINS = 2;
   localparam int SYNC_PIN_OSC = 0;
   localparam int SYNC_PIN_FAST = 1;
   // timeout in watchdog ticks for each clock source
   localparam logic [15:0] SLOW_TIMEOUT = 16'h0100;
   localparam logic [15:0] FAST_TIMEOUT = 16'h0010;
   // reset pulse length in system clocks
   localparam logic [3:0] RST_PULSE_LEN = 4'h4;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [3:0] PULSE_CNT_RST = 4'h0;
   localparam logic FLAG_RST = 1'b0;
endpackage

// ==== watch_timer.sv ====
// watchdog timer with slow-rc or system-clock tick and power-down support
// Behaviour
// - halted while slow rc oscillator is off
// - keeps timing through stop; resets on expiry
// - tick from slow rc, or sysclk in fast wakeup
// - fast wakeup gives much shorter timeout
// - clock mode bit 1 enables watchdog
// - clock mode bit 2 enables slow rc oscillator
module watch_timer (
   input wire logic i_mclk, // system clock, 100 MHz
   input wire logic i_srst, // synchronous reset, active high
   input wire logic i_ce, // clock enable, freezes all state when low
   input wire logic [7:0] i_clock_mode_reg, // clock mode register value
   input wire logic i_fast_wakeup, // fast wakeup config select
   input wire logic i_slow_internal_rc_osc, // slow rc oscillator pin
   input wire logic i_stopped, // core is in stop-system or stop-exe
   input wire logic i_clear, // watchdog clear instruction pulse
   output logic o_watch_reset, // device reset request
   output logic o_use_sysclk, // current tick source is system clock
   output logic [15:0] o_count // current watchdog count
);
   typedef enum logic [1:0] {
      SRC_SLOW = 2'b01,
      SRC_FAST = 2'b10
   } src_t;

   logic [watch_timer_pkg::SYNC_PINS-1:0] pin_raw;
   logic [watch_timer_pkg::SYNC_PINS-1:0] pin_sync;
   logic osc_dly_ff, nxt_osc_dly;
   src_t src_ff, nxt_src;
   logic use_sys_ff, nxt_use_sys;
   logic [watch_timer_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [3:0] rst_ff, nxt_rst;
   logic wrst_ff, nxt_wrst;
   logic timer_en;
   logic osc_en;
   logic osc_lvl;
   logic fast_sel;
   logic clear_ok;
   logic slow_tick;
   logic tick;
   logic expired;
   logic busy;
   logic fire;
   logic [15:0] limit;

   // true while the system clock drives the count
   function automatic logic is_fast(input src_t src);
      is_fast = (src == SRC_FAST);
   endfunction

   // timeout length for the given source
   function automatic logic [15:0] limit_of(input src_t src);
      if (is_fast(src)) begin
         limit_of = watch_timer_pkg::FAST_TIMEOUT;
      end else begin
         limit_of = watch_timer_pkg::SLOW_TIMEOUT;
      end
   endfunction

   assign pin_raw[watch_timer_pkg::SYNC_PIN_OSC] = i_slow_internal_rc_osc;
   assign pin_raw[watch_timer_pkg::SYNC_PIN_FAST] = i_fast_wakeup;

   // two flops per pin; only the second flop is read
   generate
      for (genvar g = 0; g < watch_timer_pkg::SYNC_PINS; g++) begin : g_sync
         logic s1_ff, nxt_s1;
         logic s2_ff, nxt_s2;

         always_comb begin
            nxt_s1 = pin_raw[g];
            nxt_s2 = s1_ff;
         end

         always_ff @(posedge i_mclk) begin
            if (i_srst) begin
               s1_ff <= watch_timer_pkg::FLAG_RST;
               s2_ff <= watch_timer_pkg::FLAG_RST;
            end else if (i_ce) begin
               s1_ff <= nxt_s1;
               s2_ff <= nxt_s2;
            end
         end

         assign pin_sync[g] = s2_ff;
      end
   endgenerate

   assign timer_en =
      i_clock_mode_reg[watch_timer_pkg::MODE_TIMER_EN_BIT];
   assign osc_en =
      i_clock_mode_reg[watch_timer_pkg::MODE_OSC_EN_BIT];
   assign osc_lvl = pin_sync[watch_timer_pkg::SYNC_PIN_OSC];
   assign fast_sel = pin_sync[watch_timer_pkg::SYNC_PIN_FAST];

   // a stopped core cannot execute a clear, so timing goes on
   assign clear_ok = i_clear & ~i_stopped;

   // rc oscillator off means no slow ticks at all
   assign slow_tick = osc_en & osc_lvl & ~osc_dly_ff;
   assign tick = is_fast(src_ff) | slow_tick;
   assign limit = limit_of(src_ff);
   assign expired = (cnt_ff >= limit - 16'h0001);

   // reset pulse still running
   assign busy = (rst_ff != watch_timer_pkg::PULSE_CNT_RST);

   // counted tick at the last count; no ticks while rc is off
   assign fire = !busy && timer_en && !clear_ok && tick && osc_en && expired;

   // delayed copy of the rc level for rising-edge detection
   always_comb begin
      nxt_osc_dly = osc_lvl;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         osc_dly_ff <= watch_timer_pkg::FLAG_RST;
      end else if (i_ce) begin
         osc_dly_ff <= nxt_osc_dly;
      end
   end

   // switch to fast only on a slow edge or while idle: no partial tick
   always_comb begin
      nxt_src = src_ff;
      unique case (src_ff)
         SRC_SLOW: begin
            if (fast_sel && (slow_tick || !timer_en || !osc_en)) begin
               nxt_src = SRC_FAST;
            end
         end
         SRC_FAST: begin
            if (!fast_sel) begin
               nxt_src = SRC_SLOW;
            end
         end
         default: begin
            nxt_src = SRC_SLOW;
         end
      endcase
      nxt_use_sys = is_fast(nxt_src);
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         src_ff <= SRC_SLOW;
         use_sys_ff <= watch_timer_pkg::FLAG_RST;
      end else if (i_ce) begin
         src_ff <= nxt_src;
         use_sys_ff <= nxt_use_sys;
      end
   end

   // reset pulse length counter
   always_comb begin
      nxt_rst = rst_ff;
      nxt_wrst = 1'b0;
      if (busy) begin
         nxt_rst = rst_ff - 4'h1;
         nxt_wrst = 1'b1;
      end else if (fire) begin
         nxt_rst = watch_timer_pkg::RST_PULSE_LEN - 4'h1;
         nxt_wrst = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rst_ff <= watch_timer_pkg::PULSE_CNT_RST;
         wrst_ff <= watch_timer_pkg::FLAG_RST;
      end else if (i_ce) begin
         rst_ff <= nxt_rst;
         wrst_ff <= nxt_wrst;
      end
   end

   // count held at zero during the pulse, when off and on clear
   always_comb begin
      nxt_cnt = cnt_ff;
      if (busy || fire) begin
         nxt_cnt = watch_timer_pkg::CNT_RST;
      end else if (!timer_en || clear_ok) begin
         nxt_cnt = watch_timer_pkg::CNT_RST;
      end else if (tick && osc_en) begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cnt_ff <= watch_timer_pkg::CNT_RST;
      end else if (i_ce) begin
         cnt_ff <= nxt_cnt;
      end
   end

   // all outputs come straight from flops
   assign o_watch_reset = wrst_ff;
   assign o_use_sysclk = use_sys_ff;
   assign o_count = cnt_ff;
endmodule

// ==== watch_timer_checker.sv ====
// assertions for the watchdog block
module watch_timer_checker(input wire logic i_mclk,input wire logic i_srst,
   input wire logic [7:0] i_clock_mode_reg,input wire logic i_clear,
   input wire logic i_fast_wakeup,input wire logic o_watch_reset,
   input wire logic o_use_sysclk,input wire logic [15:0] o_count);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   sequence s_pulse;
      (o_watch_reset && o_count==16'h0)[*4] ##1 !o_watch_reset;
   endsequence
   property p_off; !i_clock_mode_reg[1] |=> o_count==16'h0; endproperty
   a_off: assert property (p_off) else $error("count kept");
   property p_osc; !i_clock_mode_reg[2] |=>
      o_count==16'h0 || $stable(o_count); endproperty
   a_osc: assert property (p_osc) else $error("count moved");
   property p_fast; o_use_sysclk && i_clock_mode_reg[2:1]==2'h3 &&
      !i_clear && !o_watch_reset && o_count<16'hf |=>
      o_count==$past(o_count)+16'h1;
   endproperty
   a_fast: assert property (p_fast) else $error("no fast step");
   property p_exp; o_use_sysclk && i_clock_mode_reg[2:1]==2'h3 &&
      !i_clear && o_count==16'hf |=> $rose(o_watch_reset); endproperty
   a_exp: assert property (p_exp) else $error("no expiry");
   property p_pulse; $rose(o_watch_reset) |-> s_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("bad pulse");
   property p_slow; !o_use_sysclk && o_count==$past(o_count)+16'h1 |=>
      o_count!=$past(o_count)+16'h1 || o_use_sysclk; endproperty
   a_slow: assert property (p_slow) else $error("slow too fast");
   property p_sel; $rose(o_use_sysclk) |-> $past(i_fast_wakeup,2);
   endproperty
   a_sel: assert property (p_sel) else $error("bad select");
endmodule

// ==== watch_timer_bench.sv ====
// bench for the watchdog block
module watch_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk=0,i_srst=1,i_fast_wakeup=0,i_slow_internal_rc_osc=0;
   logic i_stopped=0,i_clear=0,o_watch_reset,o_use_sysclk,prev=0,clr_on=0;
   logic [7:0] i_clock_mode_reg=8'h00;
   logic [15:0] o_count;
   int error_cnt=0,checked=0,cyc=0,t0=0,q[$];
   watch_timer dut_u(.i_mclk,.i_srst,.i_ce(1'b1),.i_clock_mode_reg,
      .i_fast_wakeup,.i_slow_internal_rc_osc,.i_stopped,.i_clear,
      .o_watch_reset,.o_use_sysclk,.o_count);
   initial forever #5 i_mclk=~i_mclk;
   always @(posedge i_mclk) begin
      if (cyc%4==0) i_slow_internal_rc_osc<=~i_slow_internal_rc_osc;
      i_clear<=clr_on && ($urandom%8==0 || cyc%8==0);
   end
   // a reset with no note pending is a mismatch
   always @(negedge i_mclk) begin
      cyc<=cyc+1;
      prev<=o_watch_reset;
      if (o_watch_reset===1'b1 && prev!==1'b1) begin
         if (q.size()==0) check(0,99);
         else check(cyc-t0,q.pop_front());
      end
   end
   task check(input int got,input int exp);
      checked++;
      if (got>exp+12 || got+12<exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h",$time,got,exp);
      end
   endtask
   task run(input logic [7:0] m,input logic f,input int e,input int n);
      int i;
      i_fast_wakeup<=f;
      repeat(8) @(posedge i_mclk);
      i_clock_mode_reg<=m;
      t0=cyc;
      if (e) q.push_back(e);
      for (i=0;i<n && o_watch_reset!==1'b1;i++) @(negedge i_mclk);
      @(posedge i_mclk);
      i_clock_mode_reg<=8'h04;
      if (e && i==n) begin
         error_cnt++;
         stop_test;
      end
      if (!e) check(i,n);
      repeat(8) @(posedge i_mclk);
      $display("test done mode %h fast %h",m,f);
   endtask
   task stop_test;
      $display("checked %0d errors %0d",checked,error_cnt);
      if (error_cnt==0 && checked>0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      void'($urandom(59464));
      repeat(6) @(posedge i_mclk);
      i_srst<=0;
      i_stopped<=1;
      run(8'h06,0,2048,3000);
      run(8'h02,0,0,3000);
      run(8'h02,1,0,100);
      run(8'h06,1,17,100);
      run(8'h04,1,0,200);
      i_stopped<=0;
      clr_on<=1;
      run(8'h06,1,0,300);
      clr_on<=0;
      i_stopped<=1;
      run(8'h06,0,2048,3000);
      stop_test;
   end
endmodule
bind watch_timer watch_timer_checker chk_u(.i_mclk(i_mclk),
   .i_srst(i_srst),.i_clock_mode_reg(i_clock_mode_reg),.i_clear(i_clear),
   .i_fast_wakeup(i_fast_wakeup),.o_watch_reset(o_watch_reset),
   .o_use_sysclk(o_use_sysclk),.o_count(o_count));
